/* include/clmid_pkg.sv */
// Purpose: Constants and types for the character display instruction decoder
// Assumes: 8-bit instruction byte already assembled from the host bus
// Notes:   Execution time is a fixed count of system clocks
package clmid_pkg;
   localparam int         CLMID_EXEC_NS        = 26300;
   localparam int         CLMID_CLK_NS         = 10;
   localparam int         CLMID_EXEC_CYC       = CLMID_EXEC_NS / CLMID_CLK_NS;
   localparam int         CLMID_CNT_W          = 12;
   localparam logic [6:0] CLMID_ONE_LINE_LAST  = 7'h4f;
   localparam logic [6:0] CLMID_L1_LAST        = 7'h27;
   localparam logic [6:0] CLMID_L2_FIRST       = 7'h40;
   localparam logic [6:0] CLMID_L2_LAST        = 7'h67;
   localparam logic [6:0] CLMID_ADDR_ZERO      = 7'h00;
   localparam logic [6:0] CLMID_GLYPH_MASK     = 7'h3f;
   localparam logic [6:0] CLMID_ADDR_ONE       = 7'h01;
   localparam logic [6:0] CLMID_SHIFT_LAST     = 7'h27;
   localparam logic [6:0] CLMID_SHIFT_ONE      = 7'h01;
   localparam int         CLMID_BIT_STEP_DIR   = 1;
   localparam int         CLMID_BIT_SHIFT_EN   = 0;
   localparam int         CLMID_BIT_DISP       = 2;
   localparam int         CLMID_BIT_CURSOR     = 1;
   localparam int         CLMID_BIT_BLINK      = 0;
   localparam int         CLMID_BIT_SC         = 3;
   localparam int         CLMID_BIT_RL         = 2;
   localparam int         CLMID_BIT_DL         = 4;
   localparam int         CLMID_BIT_N          = 3;
   localparam int         CLMID_BIT_DH         = 2;
   localparam int         CLMID_BIT_IS         = 0;
   localparam int         CLMID_BLINK_HALF     = 50;
   localparam int         CLMID_OP_TEXT_ADDR   = 7;
   localparam int         CLMID_OP_GLYPH_ADDR  = 6;
   localparam int         CLMID_OP_FUNC        = 5;
   localparam int         CLMID_OP_SHIFT       = 4;
   localparam int         CLMID_OP_DISP        = 3;
   localparam int         CLMID_OP_ENTRY       = 2;

   typedef enum logic [1:0] {
      CLMID_IDLE = 2'b01,
      CLMID_BUSY = 2'b10
   } clmid_state_t;

   typedef struct packed {
      clmid_state_t           state;
      logic [CLMID_CNT_W-1:0] busy_cnt;
      logic [6:0]             addr_counter;
      logic                   target_glyph;
      logic                   step_dir;
      logic                   shift_en;
      logic                   disp_on;
      logic                   cursor_on;
      logic                   blink_on;
      logic                   bus_width_sel;
      logic                   two_line;
      logic                   tall_font_sel;
      logic                   instr_table_sel;
      logic [6:0]             disp_shift;
      logic [6:0]             blink_cnt;
      logic                   blink_phase;
      logic                   strap_s1;
      logic                   strap_s2;
   } clmid_reg_t;
endpackage

/* logic/clmid_decoder.sv */
// Purpose: Decodes mode instructions, keeps the address counter and display shift
// Assumes: Instruction and data strobes come from host interface logic on CLK_SYS
// Notes:   Data RAM itself lives outside; this block only sets and steps its address
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module clmid_decoder
   import clmid_pkg::*;
(
   input  wire logic       CLK_SYS,
   input  wire logic       RSTN,
   input  wire logic       INSTR_VALID,
   input  wire logic [7:0] INSTR_BYTE,
   input  wire logic       DATA_ACCESS,
   input  wire logic       DATA_WRITE,
   input  wire logic       EXTENSION_STRAP,
   output logic            OP_IN_PROGRESS_FLAG,
   output logic [6:0]      ADDR_COUNTER,
   output logic            TARGET_GLYPH_RAM,
   output logic            BUS_WIDTH_SEL,
   output logic            TWO_LINE_MODE,
   output logic            TALL_FONT_ACTIVE,
   output logic            INSTR_TABLE_SEL,
   output logic            DISPLAY_ENABLE,
   output logic            CURSOR_VISIBLE,
   output logic            BLINK_ALL_ON,
   output logic            STEP_DIR,
   output logic            SHIFT_EN,
   output logic [6:0]      DISPLAY_SHIFT
);

   ////////////////////////////////////////////////////////////////////////////
   clmid_reg_t r;
   clmid_reg_t next_r;

   // Step with wrap per line mode; tall font narrows the range
   function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                            input logic two, input logic tall,
                                            input logic glyph);
      logic [6:0] n;
      n = up ? 7'(a + CLMID_ADDR_ONE) : 7'(a - CLMID_ADDR_ONE);
      if (glyph) begin
         n = n & CLMID_GLYPH_MASK;
      end else if (two) begin
         if (up && a == CLMID_L1_LAST) n = CLMID_L2_FIRST;
         else if (up && a == CLMID_L2_LAST) n = CLMID_ADDR_ZERO;
         else if (!up && a == CLMID_L2_FIRST) n = CLMID_L1_LAST;
         else if (!up && a == CLMID_ADDR_ZERO) n = CLMID_L2_LAST;
      end else begin
         if (tall) begin
            if (up && a == CLMID_L1_LAST) n = CLMID_ADDR_ZERO;
            else if (!up && a == CLMID_ADDR_ZERO) n = CLMID_L1_LAST;
         end else begin
            if (up && a == CLMID_ONE_LINE_LAST) n = CLMID_ADDR_ZERO;
            else if (!up && a == CLMID_ADDR_ZERO) n = CLMID_ONE_LINE_LAST;
         end
      end
      return n;
   endfunction

   // Shift offset modulo 40 positions in every line mode so all lines move together
   function automatic logic [6:0] shift_step(input logic [6:0] s, input logic left);
      logic [6:0] n;
      if (left) n = (s == CLMID_SHIFT_LAST) ? CLMID_ADDR_ZERO : 7'(s + CLMID_SHIFT_ONE);
      else      n = (s == CLMID_ADDR_ZERO) ? CLMID_SHIFT_LAST : 7'(s - CLMID_SHIFT_ONE);
      return n;
   endfunction

   logic tall_eff;
   assign tall_eff = r.tall_font_sel & ~r.strap_s2 & ~r.two_line;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r = r;
      // Strap is a pin: two flops before use
      next_r.strap_s1 = EXTENSION_STRAP;
      next_r.strap_s2 = r.strap_s1;

      // Blink phase free runs; only shown when blink enabled
      if (r.blink_cnt == 7'(CLMID_BLINK_HALF - 1)) begin
         next_r.blink_cnt   = CLMID_ADDR_ZERO;
         next_r.blink_phase = ~r.blink_phase;
      end else begin
         next_r.blink_cnt = 7'(r.blink_cnt + CLMID_ADDR_ONE);
      end

      case (r.state)
         CLMID_IDLE: begin
            // Instruction wins over a same-cycle data access; host must not overlap them
            if (INSTR_VALID) begin
               next_r.state    = CLMID_BUSY;
               next_r.busy_cnt = CLMID_CNT_W'(CLMID_EXEC_CYC - 1);
               if (INSTR_BYTE[CLMID_OP_TEXT_ADDR]) begin
                  next_r.addr_counter = INSTR_BYTE[6:0];
                  next_r.target_glyph = 1'b0;
               end else if (INSTR_BYTE[CLMID_OP_GLYPH_ADDR]) begin
                  if (!r.instr_table_sel) begin
                     next_r.addr_counter = INSTR_BYTE[6:0] & CLMID_GLYPH_MASK;
                     next_r.target_glyph = 1'b1;
                  end
               end else if (INSTR_BYTE[CLMID_OP_FUNC]) begin
                  next_r.bus_width_sel   = INSTR_BYTE[CLMID_BIT_DL];
                  next_r.two_line        = INSTR_BYTE[CLMID_BIT_N];
                  next_r.tall_font_sel   = INSTR_BYTE[CLMID_BIT_DH];
                  next_r.instr_table_sel = INSTR_BYTE[CLMID_BIT_IS];
               end else if (INSTR_BYTE[CLMID_OP_SHIFT]) begin
                  // Extension table reuses this code; not handled here
                  if (!r.instr_table_sel) begin
                     if (INSTR_BYTE[CLMID_BIT_SC]) begin
                        next_r.disp_shift = shift_step(r.disp_shift,
                                                       ~INSTR_BYTE[CLMID_BIT_RL]);
                     end else begin
                        next_r.addr_counter = step_addr(r.addr_counter,
                                                        INSTR_BYTE[CLMID_BIT_RL],
                                                        r.two_line, tall_eff,
                                                        r.target_glyph);
                     end
                  end
               end else if (INSTR_BYTE[CLMID_OP_DISP]) begin
                  next_r.disp_on   = INSTR_BYTE[CLMID_BIT_DISP];
                  next_r.cursor_on = INSTR_BYTE[CLMID_BIT_CURSOR];
                  next_r.blink_on  = INSTR_BYTE[CLMID_BIT_BLINK];
               end else if (INSTR_BYTE[CLMID_OP_ENTRY]) begin
                  next_r.step_dir = INSTR_BYTE[CLMID_BIT_STEP_DIR];
                  next_r.shift_en = INSTR_BYTE[CLMID_BIT_SHIFT_EN];
               end
            end else if (DATA_ACCESS) begin
               next_r.state    = CLMID_BUSY;
               next_r.busy_cnt = CLMID_CNT_W'(CLMID_EXEC_CYC - 1);
               next_r.addr_counter = step_addr(r.addr_counter, r.step_dir, r.two_line,
                                               tall_eff, r.target_glyph);
               if (r.shift_en && DATA_WRITE && !r.target_glyph) begin
                  next_r.disp_shift = shift_step(r.disp_shift, r.step_dir);
               end
            end
         end
         CLMID_BUSY: begin
            if (r.busy_cnt == '0) next_r.state = CLMID_IDLE;
            else next_r.busy_cnt = CLMID_CNT_W'(r.busy_cnt - 1'b1);
         end
         default: next_r.state = CLMID_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         r                 <= '0;
         r.state           <= CLMID_IDLE;
         r.step_dir        <= 1'b1;
         r.bus_width_sel   <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign OP_IN_PROGRESS_FLAG = (r.state == CLMID_BUSY);
   assign ADDR_COUNTER        = r.addr_counter;
   assign TARGET_GLYPH_RAM    = r.target_glyph;
   assign BUS_WIDTH_SEL       = r.bus_width_sel;
   assign TWO_LINE_MODE       = r.two_line;
   assign TALL_FONT_ACTIVE    = tall_eff;
   assign INSTR_TABLE_SEL     = r.instr_table_sel;
   assign DISPLAY_ENABLE      = r.disp_on;
   assign CURSOR_VISIBLE      = r.disp_on & r.cursor_on;
   assign BLINK_ALL_ON        = r.disp_on & r.blink_on & r.blink_phase;
   assign STEP_DIR            = r.step_dir;
   assign SHIFT_EN            = r.shift_en;
   assign DISPLAY_SHIFT       = r.disp_shift;
endmodule

/* testbench/clmid_host.sv */
// Purpose: Host model driving instruction and data strobes
// Assumes: One strobe per request, busy polled at negedge
// Notes:   Released byte lines show inverted data
`timescale 1ns/1ps
module clmid_host (
   input  wire logic       CLK_SYS,
   input  wire logic       BUSY,
   output logic            INSTR_VALID = 1'b0,
   output logic [7:0]      INSTR_BYTE = 8'h00,
   output logic            DATA_ACCESS = 1'b0,
   output logic            DATA_WRITE = 1'b0
);
   // Raw strobe, no busy check; kind 0 instr, 2 read, 3 write
   task automatic pulse(input logic [7:0] b, input logic [1:0] k);
      @(posedge CLK_SYS);
      INSTR_VALID <= (k == 2'h0);
      INSTR_BYTE  <= b;
      DATA_ACCESS <= k[1];
      DATA_WRITE  <= k[0];
      @(posedge CLK_SYS);
      INSTR_VALID <= 1'b0;
      DATA_ACCESS <= 1'b0;
      INSTR_BYTE  <= ~b;
   endtask
   // Next request only once busy is low again
   task automatic send(input logic [7:0] b, input logic [1:0] k);
      int n;
      pulse(b, k);
      n = 0;
      @(negedge CLK_SYS);
      while (BUSY && n < 3000) begin
         @(negedge CLK_SYS);
         n++;
      end
   endtask
endmodule

/* testbench/clmid_decoder_asserts.sv */
// Purpose: Port level checks of the instruction decoder
// Assumes: Single clock, sync active low reset
// Notes:   Address check limited to line one range
`timescale 1ns/1ps
module clmid_decoder_asserts (
   input wire logic       CLK_SYS,
   input wire logic       RSTN,
   input wire logic       INSTR_VALID,
   input wire logic [7:0] INSTR_BYTE,
   input wire logic       DATA_ACCESS,
   input wire logic       DATA_WRITE,
   input wire logic       OP_IN_PROGRESS_FLAG,
   input wire logic [6:0] ADDR_COUNTER,
   input wire logic       TARGET_GLYPH_RAM,
   input wire logic       BUS_WIDTH_SEL,
   input wire logic       TWO_LINE_MODE,
   input wire logic       TALL_FONT_ACTIVE,
   input wire logic       INSTR_TABLE_SEL,
   input wire logic       DISPLAY_ENABLE,
   input wire logic       STEP_DIR,
   input wire logic       SHIFT_EN,
   input wire logic [6:0] DISPLAY_SHIFT
);
   logic [11:0] busy_len;
   wire         take = INSTR_VALID && !OP_IN_PROGRESS_FLAG;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   always_ff @(posedge CLK_SYS) begin
      busy_len <= (!RSTN || !OP_IN_PROGRESS_FLAG) ? 12'h000 : busy_len + 12'h001;
   end
   sequence s_take;
      take;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   AST_TAKE_BUSY: assert property (s_take |=> OP_IN_PROGRESS_FLAG)
      else $error("busy did not rise");
   AST_REFUSE: assert property (OP_IN_PROGRESS_FLAG && INSTR_VALID |=> $stable(ADDR_COUNTER))
      else $error("request taken while busy");
   AST_BUSY_LEN: assert property ($fell(OP_IN_PROGRESS_FLAG) |-> busy_len == 12'ha46)
      else $error("busy length wrong");
   AST_ENTRY: assert property (s_take ##0 INSTR_BYTE[7:2] == 6'h01 |=>
      STEP_DIR == $past(INSTR_BYTE[1]) && SHIFT_EN == $past(INSTR_BYTE[0])) else $error("entry mode");
   AST_DISP: assert property (s_take ##0 INSTR_BYTE[7:3] == 5'h01 |=> DISPLAY_ENABLE == $past(INSTR_BYTE[2]))
      else $error("display control");
   AST_FUNC: assert property (s_take ##0 INSTR_BYTE[7:5] == 3'h1 |=> BUS_WIDTH_SEL == $past(INSTR_BYTE[4])
      && TWO_LINE_MODE == $past(INSTR_BYTE[3]) && INSTR_TABLE_SEL == $past(INSTR_BYTE[0])) else $error("function set");
   AST_TEXT_ADDR: assert property (s_take ##0 INSTR_BYTE[7] && INSTR_BYTE[6:0] <= 7'h27 |=>
      ADDR_COUNTER == $past(INSTR_BYTE[6:0]) && !TARGET_GLYPH_RAM) else $error("text address set");
   AST_DSHIFT_AC: assert property (s_take ##0 !INSTR_TABLE_SEL && INSTR_BYTE[7:3] == 5'h03 |=>
      $stable(ADDR_COUNTER)) else $error("display shift moved counter");
   AST_READ_NOSHIFT: assert property (DATA_ACCESS && !DATA_WRITE && !INSTR_VALID && !OP_IN_PROGRESS_FLAG
      |=> $stable(DISPLAY_SHIFT)) else $error("read shifted display");
   AST_TALL: assert property (TALL_FONT_ACTIVE |-> !TWO_LINE_MODE)
      else $error("tall font in two line mode");
endmodule
bind clmid_decoder clmid_decoder_asserts i_clmid_decoder_asserts (.*);

/* testbench/clmid_decoder_test.sv */
// Purpose: Directed test of the instruction decoder
// Assumes: Busy time fixed, blink half period short
// Notes:   Each request but the one raw pulse waits out busy through the host model
`timescale 1ns/1ps
module clmid_decoder_test;
   logic       CLK_SYS;
   logic       RSTN = 1'b0;
   logic       strap = 1'b0;
   logic       iv, da, dw, busy, glyph, bw, two, tall, tsel, den, cur, blink, step, sen;
   logic [7:0] ib;
   logic [6:0] ac, dsh;
   int         bad_count, compares, cyc, n;
   initial begin
      CLK_SYS = 1'b0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end
   clmid_host i_clmid_host (.CLK_SYS(CLK_SYS), .BUSY(busy), .INSTR_VALID(iv), .INSTR_BYTE(ib),
      .DATA_ACCESS(da), .DATA_WRITE(dw));
   clmid_decoder i_clmid_decoder (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .INSTR_VALID(iv), .INSTR_BYTE(ib),
      .DATA_ACCESS(da), .DATA_WRITE(dw), .EXTENSION_STRAP(strap), .OP_IN_PROGRESS_FLAG(busy),
      .ADDR_COUNTER(ac), .TARGET_GLYPH_RAM(glyph), .BUS_WIDTH_SEL(bw), .TWO_LINE_MODE(two),
      .TALL_FONT_ACTIVE(tall), .INSTR_TABLE_SEL(tsel), .DISPLAY_ENABLE(den), .CURSOR_VISIBLE(cur),
      .BLINK_ALL_ON(blink), .STEP_DIR(step), .SHIFT_EN(sen), .DISPLAY_SHIFT(dsh));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic stop_test;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end
      else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Longest run is about 61k cycles
   always @(posedge CLK_SYS) begin
      cyc++;
      if (cyc == 90000) begin
         bad_count++;
         stop_test;
      end
   end
   initial begin
      repeat (4) @(posedge CLK_SYS);
      RSTN <= 1'b1;
      i_clmid_host.send(8'h24, 2'h0); // Tall font only with one line, test bit zero
      chk("bus_width", 7'h00, {6'h00, bw});
      chk("tall", 7'h01, {6'h00, tall});
      strap <= 1'b1;
      repeat (4) @(posedge CLK_SYS);
      chk("tall_strap", 7'h00, {6'h00, tall});
      strap <= 1'b0;
      i_clmid_host.send(8'h38, 2'h0);
      chk("two_line", 7'h01, {6'h00, two});
      i_clmid_host.send(8'ha7, 2'h0);
      chk("addr", 7'h27, ac);
      i_clmid_host.send(8'h06, 2'h0);
      i_clmid_host.send(8'h00, 2'h3);
      chk("addr", 7'h40, ac);
      chk("shift", 7'h00, dsh);
      i_clmid_host.send(8'h07, 2'h0);
      i_clmid_host.send(8'h00, 2'h3);
      chk("shift", 7'h01, dsh);
      i_clmid_host.send(8'h00, 2'h2);
      chk("addr", 7'h42, ac);
      chk("shift", 7'h01, dsh);
      i_clmid_host.send(8'h05, 2'h0);
      i_clmid_host.send(8'h00, 2'h3);
      chk("addr", 7'h41, ac);
      chk("shift", 7'h00, dsh);
      i_clmid_host.send(8'h7f, 2'h0);
      chk("glyph", 7'h01, {6'h00, glyph});
      i_clmid_host.send(8'h00, 2'h3);
      chk("addr", 7'h3e, ac);
      chk("shift", 7'h00, dsh);
      i_clmid_host.send(8'h80, 2'h0);
      chk("glyph", 7'h00, {6'h00, glyph});
      i_clmid_host.send(8'h14, 2'h0);
      chk("addr", 7'h01, ac);
      i_clmid_host.send(8'h10, 2'h0);
      chk("addr", 7'h00, ac);
      i_clmid_host.send(8'h18, 2'h0);
      chk("shift", 7'h01, dsh);
      chk("addr", 7'h00, ac);
      i_clmid_host.send(8'h0f, 2'h0);
      chk("cursor", 7'h01, {6'h00, cur});
      while (blink !== 1'b1 && n < 120) begin
         @(negedge CLK_SYS);
         n++;
      end
      chk("blink", 7'h01, {6'h00, blink});
      i_clmid_host.send(8'h09, 2'h0);
      chk("cursor", 7'h00, {6'h00, cur});
      chk("step", 7'h00, {6'h00, step});
      i_clmid_host.send(8'h08, 2'h0);
      chk("display", 7'h00, {6'h00, den});
      i_clmid_host.send(8'h39, 2'h0);
      chk("table", 7'h01, {6'h00, tsel});
      i_clmid_host.send(8'h14, 2'h0);
      chk("addr", 7'h00, ac);
      i_clmid_host.send(8'h38, 2'h0);
      i_clmid_host.pulse(8'h85, 2'h0);
      i_clmid_host.send(8'h86, 2'h0);
      chk("addr", 7'h05, ac);
      stop_test;
   end
endmodule
